// >>> test/flash_cmd_monitor.sv
// checker: concurrent assertions on the flash command core ports
// assumes it is bound into every flash_cmd_core instance
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_monitor #(
	parameter int unsigned BLOCK_ERASE_CYCLES = 200,
	parameter int unsigned ARRAY_ERASE_CYCLES = 200
) (
	input wire logic                    sys_clk_i,
	input wire logic                    rst_b_i,
	input wire logic                    sel_b_i,
	input wire flash_cmd_pkg::protect_s protect_i,
	input wire logic                    io0_oe_b_o,
	input wire logic                    io1_oe_b_o,
	input wire logic                    write_in_progress_o,
	input wire logic                    write_latch_flag_o,
	input wire logic                    deep_sleep_o,
	input wire logic                    block_erase_o,
	input wire logic                    array_erase_o
);
	logic [15:0] hi_cnt_reg;
	// cycles since select went high, saturating so long idle spans stay legal
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i || !sel_b_i)
			hi_cnt_reg <= 16'h0000;
		else if (hi_cnt_reg != 16'hFFFF)
			hi_cnt_reg <= hi_cnt_reg + 16'h0001;
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	a_erase_needs_latch: assert property ($rose(write_in_progress_o) |-> $past(write_latch_flag_o))
		else $error("erase began without write latch");
	a_block_busy_holds: assert property (block_erase_o |-> ##2 write_in_progress_o [*8])
		else $error("block erase busy flag dropped early");
	a_array_busy_holds: assert property (array_erase_o |-> ##2 write_in_progress_o [*8])
		else $error("array erase busy flag dropped early");
	a_array_unprotected: assert property (array_erase_o |-> (protect_i.protect_bits[2:0] == 3'h0
		&& !protect_i.protect_complement) || (protect_i.protect_bits[2:0] == 3'h7 && protect_i.protect_complement))
		else $error("array erase with protected sectors");
	a_latch_cleared_end: assert property ($fell(write_in_progress_o) |-> !write_latch_flag_o)
		else $error("write latch still set after erase");
	a_sleep_not_busy: assert property ($rose(deep_sleep_o) |-> !write_in_progress_o)
		else $error("sleep entered during busy cycle");
	a_asleep_no_erase: assert property (deep_sleep_o |-> !(block_erase_o || array_erase_o || $rose(write_latch_flag_o)))
		else $error("erase started while asleep");
	a_start_deselected: assert property ((block_erase_o || array_erase_o) |-> sel_b_i)
		else $error("erase started with select low");
	a_sleep_entry_delay: assert property ($rose(deep_sleep_o) |-> hi_cnt_reg >= 16'h0122)
		else $error("sleep entered too early");
	a_id_released: assert property ($rose(sel_b_i) |-> ##[1:8] (io0_oe_b_o && io1_oe_b_o))
		else $error("id lines still driven after deselect");
endmodule // flash_cmd_monitor
bind flash_cmd_core flash_cmd_monitor #(
	.BLOCK_ERASE_CYCLES(BLOCK_ERASE_CYCLES),
	.ARRAY_ERASE_CYCLES(ARRAY_ERASE_CYCLES)
) mon (.sys_clk_i, .rst_b_i, .sel_b_i, .protect_i, .io0_oe_b_o, .io1_oe_b_o, .write_in_progress_o,
	.write_latch_flag_o, .deep_sleep_o, .block_erase_o, .array_erase_o);
`default_nettype wire

// >>> test/spi_host_model.sv
// host side of the serial link: select, clock and data frames
// assumes nothing of the system clock; link clock idles low between frames
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
	output logic      sclk_o,
	output logic      sel_b_o,
	output logic      io0_o,
	output logic      io1_o,
	input  wire logic io0_i,
	input  wire logic io1_i
);
	initial begin
		sclk_o = 1'h0;
		sel_b_o = 1'h1;
		io0_o = 1'h0;
		io1_o = 1'h0;
	end
	// the host toggles the second line on every link clock rise, so it wanders rather than hold a value
	always @(posedge sclk_o) io1_o <= ~io1_o;
	task automatic xfer(input logic [63:0] tx, input int nt, input int nr, input bit dual, output logic [15:0] rx);
		rx = 16'h0000;
		sel_b_o = 1'h0;
		for (int i = 0; i < nt; i++) begin
			io0_o = tx[63 - i];
			#62.5 sclk_o = 1'h1;
			#62.5 sclk_o = 1'h0;
		end
		io0_o = ~io0_o;
		for (int i = 0; i < nr; i++) begin
			#62.5 sclk_o = 1'h1;
			// dual: the second line carries the more significant bit of each pair
			rx = dual ? {rx[13:0], io1_i, io0_i} : {rx[14:0], io1_i};
			#62.5 sclk_o = 1'h0;
		end
		#62.5 sel_b_o = 1'h1;
		io0_o = ~io0_o;
	endtask
endmodule // spi_host_model
`default_nettype wire

// >>> test/tb_top.sv
// testbench: host frames into the flash command core, checks the outputs
// assumes spi_host_model on the link and the bound port monitor
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import flash_cmd_pkg::*;
	logic        sys_clk_i  = 1'h0;
	logic        rst_b_i    = 1'h0;
	protect_s    protect    = '0;
	logic [15:0] rd;
	logic [7:0]  seen_blk   = 8'h00;
	logic        oe_seen    = 1'h0;
	int          error_cnt  = 0;
	int          num_checks = 0;
	wire logic   sclk, sel_b, h0, h1, io0_l, io1_l, d0, d0_oeb, d1, d1_oeb, busy, latch, slp, blk, arr;
	wire logic [7:0] blk_no;
	assign io0_l = d0_oeb ? h0 : d0;
	assign io1_l = d1_oeb ? h1 : d1;
	initial forever #5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		if (blk === 1'h1)
			seen_blk <= blk_no;
		if (d1_oeb === 1'h0)
			oe_seen <= 1'h1;
	end
	flash_cmd_core #(.BLOCK_ERASE_CYCLES(200), .ARRAY_ERASE_CYCLES(2000)) DUT (.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i), .sclk_i(sclk), .sel_b_i(sel_b), .io0_i(io0_l), .io1_i(io1_l), .protect_i(protect),
		.io0_o(d0), .io0_oe_b_o(d0_oeb), .io1_o(d1), .io1_oe_b_o(d1_oeb), .write_in_progress_o(busy),
		.write_latch_flag_o(latch), .deep_sleep_o(slp), .block_erase_o(blk), .array_erase_o(arr),
		.erase_block_o(blk_no));
	spi_host_model host (.sclk_o(sclk), .sel_b_o(sel_b), .io0_o(h0), .io1_o(h1), .io0_i(io0_l), .io1_i(io1_l));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask
	task automatic chb(input logic got, input logic exp, input string m);
		chk(16'(got), 16'(exp), m);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	task automatic frm(input logic [63:0] tx, input int nt, input int nr, input bit dual = 1'b0);
		host.xfer(tx, nt, nr, dual, rd);
		cyc(12);
	endtask
	task automatic idle;
		for (int i = 0; i < 2500 && busy !== 1'h0; i++)
			cyc(1);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#900000;
		error_cnt++;
		complete_run();
	end
	initial begin
		cyc(10);
		rst_b_i <= 1'h1;
		cyc(5);
		chk(16'({busy, latch, slp, d0_oeb, d1_oeb}), 16'h0003, "reset state");
		$display("test reset done");
		frm({8'hD8, 24'h3A1234, 32'h0}, 32, 0);
		chb(busy, 1'h0, "erase without latch");
		frm({8'h06, 56'h0}, 8, 0);
		chb(latch, 1'h1, "latch set");
		frm({8'hD8, 24'h3A1234, 32'h0}, 31, 0);
		chb(busy, 1'h0, "short erase frame");
		frm({8'hD8, 24'h3A1234, 32'h0}, 32, 0);
		chb(busy, 1'h1, "block erase busy");
		chk(16'(seen_blk), 16'h003A, "erased block");
		idle();
		chk(16'({busy, latch}), 16'h0000, "erase end");
		protect <= '{protect_bits: 5'h01, protect_complement: 1'h0};
		frm({8'h06, 56'h0}, 8, 0);
		frm({8'hD8, 24'hFF0000, 32'h0}, 32, 0);
		chb(busy, 1'h0, "protected block");
		frm({8'hC7, 56'h0}, 8, 0);
		chb(busy, 1'h0, "protected array");
		protect <= '0;
		$display("test block erase done");
		for (int i = 0; i < 2; i++) begin
			frm({8'h06, 56'h0}, 8, 0);
			frm({(i == 0) ? 8'h60 : 8'hC7, 56'h0}, 8, 0);
			chb(busy, 1'h1, "array erase busy");
			oe_seen <= 1'h0;
			frm({8'hB9, 56'h0}, 8, 0);
			frm({8'hAB, 56'h0}, 32, 16);
			chb(busy, 1'h1, "array erase still busy");
			idle();
			cyc(320);
			chk(16'({slp, oe_seen}), 16'h0000, "busy refusals");
		end
		$display("test array erase done");
		frm({8'hB9, 56'h0}, 9, 0);
		cyc(320);
		chb(slp, 1'h0, "long sleep frame");
		frm({8'hB9, 56'h0}, 8, 0);
		cyc(100);
		chb(slp, 1'h0, "sleep delay");
		cyc(250);
		chb(slp, 1'h1, "asleep");
		frm({8'h06, 56'h0}, 8, 0);
		chb(latch, 1'h0, "write enable ignored asleep");
		frm({8'hAB, 56'h0}, 8, 0);
		frm({8'h06, 56'h0}, 8, 0);
		chb(latch, 1'h0, "write enable during wake delay");
		cyc(320);
		chb(slp, 1'h0, "woken");
		frm({8'hB9, 56'h0}, 8, 0);
		cyc(350);
		frm({8'hAB, 56'h0}, 32, 24);
		cyc(620);
		chk(rd, {DEVICE_ID_DEF, DEVICE_ID_DEF}, "repeated device id");
		chb(slp, 1'h0, "woken by id read");
		frm({8'hB9, 56'h0}, 8, 0);
		cyc(350);
		frm({8'h66, 56'h0}, 8, 0);
		chb(slp, 1'h1, "reset enable alone stays asleep");
		frm({8'h99, 56'h0}, 8, 0);
		cyc(320);
		chb(slp, 1'h0, "reset wakes");
		$display("test sleep done");
		frm({8'h90, 56'h0}, 32, 16);
		chk(rd, {MAKER_ID_DEF, DEVICE_ID_DEF}, "maker then device");
		frm({8'h90, 24'h000001, 32'h0}, 32, 16);
		chk(rd, {DEVICE_ID_DEF, MAKER_ID_DEF}, "device then maker");
		frm({8'h92, 56'h0}, 32, 8, 1'b1);
		chk(rd, {MAKER_ID_DEF, DEVICE_ID_DEF}, "dual id read");
		$display("test id done");
		complete_run();
	end
endmodule // tb_top
`default_nettype wire

// >>> verilog/flash_cmd_core.sv
// command interpreter for erase, deep sleep and identification commands
// assumes link pins are asynchronous; the array itself lives outside
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_core #(
	parameter int unsigned BLOCK_ERASE_CYCLES = flash_cmd_pkg::BLOCK_ERASE_CYC,
	parameter int unsigned ARRAY_ERASE_CYCLES = flash_cmd_pkg::ARRAY_ERASE_CYC
) (
	input  wire logic                    sys_clk_i,
	input  wire logic                    rst_b_i,
	input  wire logic                    sclk_i,
	input  wire logic                    sel_b_i,
	input  wire logic                    io0_i,
	input  wire logic                    io1_i,
	input  wire flash_cmd_pkg::protect_s protect_i,
	output logic                         io0_o,
	output logic                         io0_oe_b_o,
	output logic                         io1_o,
	output logic                         io1_oe_b_o,
	output logic                         write_in_progress_o,
	output logic                         write_latch_flag_o,
	output logic                         deep_sleep_o,
	output logic                         block_erase_o,
	output logic                         array_erase_o,
	output logic [7:0]                   erase_block_o
);
	import flash_cmd_pkg::*;

	typedef struct packed {
		mode_e       mode;
		logic [31:0] timer;
		logic [5:0]  nbits;
		logic [39:0] shift;
		logic        rst_armed;
		logic        latch;
		logic        wake_id;
		logic [15:0] id_word;
		logic [3:0]  id_pos;
		logic        dual;
		logic        out_en;
		logic        io0;
		logic        io1;
		logic        blk_pulse;
		logic        arr_pulse;
		logic [7:0]  blk_addr;
		logic        dummy;
	} core_s;

	core_s    st_reg;
	core_s    st_next;
	link_ev_s ev;
	logic     unused_io1;

	link_sampler u_samp (
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.sclk_i    (sclk_i),
		.sel_b_i   (sel_b_i),
		.data_i    (io0_i),
		.ev_o      (ev)
	);
	assign unused_io1 = io1_i;

	// opcode is the first byte; a finished frame's bit count decides validity
	function automatic logic [7:0] opcode(input logic [39:0] sh, input logic [5:0] n);
		opcode = 8'(sh >> (6'(n) - 6'd8));
	endfunction

	function automatic logic no_sector_protected(input protect_s p);
		no_sector_protected = (p.protect_bits[2:0] == 3'h0 && !p.protect_complement) ||
			(p.protect_bits[2:0] == 3'h7 && p.protect_complement);
	endfunction

	// simplified protect map: top fraction of 256 blocks by protect_bits[2:0]
	function automatic logic block_protected(input protect_s p, input logic [7:0] blk);
		logic [8:0] lim;
		logic       hit;
		lim = (p.protect_bits[2:0] == 3'h0) ? 9'h100 : (9'h100 - (9'h001 << p.protect_bits[2:0]));
		hit = {1'b0, blk} >= lim;
		block_protected = hit ^ p.protect_complement;
	endfunction

	always_comb begin
		logic [7:0] op;
		logic [7:0] op_now;
		logic       busy;
		op = opcode(st_reg.shift, st_reg.nbits);
		op_now = st_reg.shift[7:0];
		busy = (st_reg.mode == ST_BUSY);
		st_next = st_reg;
		st_next.blk_pulse = 1'b0;
		st_next.arr_pulse = 1'b0;
		if (st_reg.timer != TIMER_RESET) begin
			st_next.timer = st_reg.timer - 32'h1;
		end
		case (st_reg.mode)
			ST_BUSY: begin
				if (st_reg.timer == 32'h2) begin
					st_next.latch = 1'b0;
				end
				if (st_reg.timer == 32'h1) begin
					st_next.mode = ST_IDLE;
				end
			end
			ST_SLEEP_WAIT: begin
				if (st_reg.timer == 32'h1) begin
					st_next.mode = ST_ASLEEP;
				end
			end
			ST_WAKING: begin
				// select held high for the delay; earlier select restarts nothing
				if (st_reg.timer == 32'h1) begin
					st_next.mode = ST_IDLE;
				end
			end
			ST_IDLE, ST_ASLEEP: begin
			end
			default: begin
				st_next.mode = ST_IDLE;
			end
		endcase
		if (ev.rise) begin
			st_next.shift = {st_reg.shift[38:0], ev.data};
			if (st_reg.nbits != 6'd63) begin
				st_next.nbits = st_reg.nbits + 6'd1;
			end
			// id output starts after 32 bits, for both the id and the wake/id forms
			if (st_reg.nbits == 6'd31 && !(st_reg.mode inside {ST_ASLEEP, ST_WAKING, ST_SLEEP_WAIT})) begin
				if ((st_reg.shift[30:23] == OP_ID_SINGLE || st_reg.shift[30:23] == OP_ID_DUAL) && !busy) begin
					st_next.out_en = 1'b1;
					st_next.dual = (st_reg.shift[30:23] == OP_ID_DUAL);
					st_next.id_pos = 4'h0;
					st_next.id_word = ({st_reg.shift[22:0], ev.data} == ADDR_SWAP) ?
						{DEVICE_ID_DEF, MAKER_ID_DEF} : {MAKER_ID_DEF, DEVICE_ID_DEF};
				end
			end
			if (st_reg.nbits == 6'd31 && st_reg.shift[30:23] == OP_WAKE_ID && !busy) begin
				st_next.out_en = 1'b1;
				st_next.dual = 1'b0;
				st_next.id_pos = 4'h0;
				st_next.id_word = {DEVICE_ID_DEF, DEVICE_ID_DEF};
				st_next.wake_id = 1'b1;
			end
		end
		if (ev.fall && st_reg.out_en) begin
			if (st_reg.dual) begin
				st_next.io1 = st_reg.id_word[4'hF - st_reg.id_pos];
				st_next.io0 = st_reg.id_word[4'hE - st_reg.id_pos];
				st_next.id_pos = st_reg.id_pos + 4'h2;
			end else begin
				st_next.io1 = st_reg.id_word[4'hF - st_reg.id_pos];
				st_next.id_pos = st_reg.id_pos + 4'h1;
			end
		end
		if (ev.sel_rise) begin
			st_next.nbits = 6'd0;
			st_next.shift = '0;
			st_next.out_en = 1'b0;
			st_next.wake_id = 1'b0;
			if (st_reg.mode == ST_ASLEEP || st_reg.mode == ST_SLEEP_WAIT) begin
				// asleep: only wake, reset-enable and reset respond
				if (st_reg.nbits == 6'd8 && op == OP_WAKE_ID) begin
					st_next.mode = ST_WAKING;
					st_next.timer = 32'(WAKE_CYC);
				end else if (st_reg.nbits >= 6'd32 && st_reg.wake_id) begin
					st_next.mode = ST_WAKING;
					st_next.timer = 32'(WAKE_ID_CYC);
				end else if (st_reg.nbits == 6'd8 && op == OP_RST_EN) begin
					st_next.rst_armed = 1'b1;
				end else if (st_reg.nbits == 6'd8 && op == OP_RST && st_reg.rst_armed) begin
					st_next.mode = ST_WAKING;
					st_next.timer = 32'(WAKE_CYC);
					st_next.latch = 1'b0;
					st_next.rst_armed = 1'b0;
				end
			end else if (st_reg.mode == ST_IDLE) begin
				st_next.rst_armed = (st_reg.nbits == 6'd8 && op == OP_RST_EN);
				if (st_reg.nbits == 6'd8 && op == OP_WRITE_ENABLE) begin
					st_next.latch = 1'b1;
				end else if (st_reg.nbits == 6'(BITS_BLOCK_CMD) && op == OP_BLOCK_ERASE) begin
					// exactly 32 bits, any address in the block
					if (st_reg.latch && !block_protected(protect_i, st_reg.shift[23:16])) begin
						st_next.mode = ST_BUSY;
						st_next.timer = BLOCK_ERASE_CYCLES;
						st_next.blk_pulse = 1'b1;
						st_next.blk_addr = st_reg.shift[23:16];
					end
				end else if (st_reg.nbits == 6'(BITS_CODE) &&
						(op == OP_ARRAY_ERA_A || op == OP_ARRAY_ERA_B)) begin
					if (st_reg.latch && no_sector_protected(protect_i)) begin
						st_next.mode = ST_BUSY;
						st_next.timer = ARRAY_ERASE_CYCLES;
						st_next.arr_pulse = 1'b1;
					end
				end else if (st_reg.nbits == 6'(BITS_CODE) && op == OP_SLEEP) begin
					st_next.mode = ST_SLEEP_WAIT;
					st_next.timer = 32'(SLEEP_ENTRY_CYC);
				end else if (st_reg.nbits == 6'd8 && op == OP_RST && st_reg.rst_armed) begin
					st_next.latch = 1'b0;
				end
				// any other deselect simply leaves the device in standby
			end
			// while busy, sleep and wake requests fall through untouched
		end
		st_next.dummy = op_now[0];
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			st_reg <= '{mode: ST_IDLE, timer: TIMER_RESET, nbits: 6'h0, shift: 40'h0,
				rst_armed: 1'b0, latch: 1'b0, wake_id: 1'b0, id_word: 16'h0, id_pos: 4'h0,
				dual: 1'b0, out_en: 1'b0, io0: 1'b0, io1: 1'b0, blk_pulse: 1'b0,
				arr_pulse: 1'b0, blk_addr: 8'h0, dummy: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			io0_o <= 1'b0;
			io1_o <= 1'b0;
			io0_oe_b_o <= 1'b1;
			io1_oe_b_o <= 1'b1;
			write_in_progress_o <= 1'b0;
			write_latch_flag_o <= 1'b0;
			deep_sleep_o <= 1'b0;
			block_erase_o <= 1'b0;
			array_erase_o <= 1'b0;
			erase_block_o <= 8'h0;
		end else begin
			io0_o <= st_next.io0;
			io1_o <= st_next.io1;
			io0_oe_b_o <= ~(st_next.out_en & st_next.dual);
			io1_oe_b_o <= ~st_next.out_en;
			write_in_progress_o <= (st_next.mode == ST_BUSY);
			write_latch_flag_o <= st_next.latch;
			deep_sleep_o <= (st_next.mode == ST_ASLEEP);
			block_erase_o <= st_next.blk_pulse;
			array_erase_o <= st_next.arr_pulse;
			erase_block_o <= st_next.blk_addr;
		end
	end
endmodule // flash_cmd_core
`default_nettype wire

// >>> verilog/flash_cmd_pkg.sv
// package for the serial flash command interpreter: opcodes, timing, types
// assumes a 100 MHz system clock that oversamples the serial link pins
`default_nettype none
package flash_cmd_pkg;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
	localparam logic [7:0] OP_ARRAY_ERA_A = 8'h60;
	localparam logic [7:0] OP_ARRAY_ERA_B = 8'hC7;
	localparam logic [7:0] OP_SLEEP      = 8'hB9;
	localparam logic [7:0] OP_WAKE_ID    = 8'hAB;
	localparam logic [7:0] OP_RST_EN     = 8'h66;
	localparam logic [7:0] OP_RST        = 8'h99;
	localparam logic [7:0] OP_ID_SINGLE  = 8'h90;
	localparam logic [7:0] OP_ID_DUAL    = 8'h92;
	localparam logic [7:0] MAKER_ID_DEF  = 8'h5A; // arbitrary value
	localparam logic [7:0] DEVICE_ID_DEF = 8'h17; // arbitrary value
	localparam int CLK_MHZ = 100;
	// times in microseconds, plain defaults
	// array time kept small enough that the cycle count still fits a 32-bit int
	localparam int BLOCK_ERASE_TIME_US = 250000;
	localparam int ARRAY_ERASE_TIME_US = 20000000;
	localparam int SLEEP_ENTRY_DELAY_US = 3;
	localparam int WAKE_DELAY_US = 3;
	localparam int WAKE_ID_DELAY_US = 6;
	localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_US * CLK_MHZ;
	localparam int ARRAY_ERASE_CYC = ARRAY_ERASE_TIME_US * CLK_MHZ;
	localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_DELAY_US * CLK_MHZ;
	localparam int WAKE_CYC = WAKE_DELAY_US * CLK_MHZ;
	localparam int WAKE_ID_CYC = WAKE_ID_DELAY_US * CLK_MHZ;
	localparam int BITS_BLOCK_CMD = 32;
	localparam int BITS_CODE = 8;
	localparam int BITS_DUMMY3 = 32;
	localparam logic [23:0] ADDR_SWAP = 24'h000001;
	localparam logic [31:0] TIMER_RESET = 32'h0000_0000;

	typedef enum logic [2:0] {ST_IDLE, ST_BUSY, ST_SLEEP_WAIT, ST_ASLEEP, ST_WAKING} mode_e;

	typedef struct packed {
		logic [4:0] protect_bits;
		logic       protect_complement;
	} protect_s;

	typedef struct packed {
		logic rise;
		logic fall;
		logic sel_low;
		logic sel_rise;
		logic data;
	} link_ev_s;
endpackage : flash_cmd_pkg
`default_nettype wire

// >>> verilog/link_sampler.sv
// link pin synchroniser and edge finder for the serial interface
// assumes serial clock, select and data arrive asynchronously to sys_clk_i
`timescale 1ns/10ps
`default_nettype none
module link_sampler (
	input  wire logic                      sys_clk_i,
	input  wire logic                      rst_b_i,
	input  wire logic                      sclk_i,
	input  wire logic                      sel_b_i,
	input  wire logic                      data_i,
	output var  flash_cmd_pkg::link_ev_s   ev_o
);
	import flash_cmd_pkg::*;

	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic       clk_d;
		logic       sel_d;
	} samp_s;

	samp_s st_reg;
	samp_s st_next;

	always_comb begin
		st_next = st_reg;
		st_next.s1 = {sclk_i, sel_b_i, data_i};
		st_next.s2 = st_reg.s1;
		st_next.clk_d = st_reg.s2[2];
		st_next.sel_d = st_reg.s2[1];
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			// idle pin levels (clock low, select high) so no false edge follows reset
			st_reg <= '{s1: 3'h2, s2: 3'h2, clk_d: 1'b0, sel_d: 1'b1};
		end else begin
			st_reg <= st_next;
		end
	end

	// events use only second-stage and later flops so metastability stays contained
	always_comb begin
		ev_o.rise = st_reg.s2[2] & ~st_reg.clk_d & ~st_reg.s2[1];
		ev_o.fall = ~st_reg.s2[2] & st_reg.clk_d & ~st_reg.s2[1];
		ev_o.sel_low = ~st_reg.s2[1];
		ev_o.sel_rise = st_reg.s2[1] & ~st_reg.sel_d;
		ev_o.data = st_reg.s2[0];
	end
endmodule // link_sampler
`default_nettype wire
